/* io_func_pkg.sv */
package io_func_pkg;
  // ***********************
  // Register indices
  // ***********************
  localparam logic [5:0] IDX_PORT5_CTRL = 6'h05;
  localparam logic [5:0] IDX_PORT6_DIR = 6'h06;
  localparam logic [5:0] IDX_PORT7_DIR = 6'h07;
  localparam logic [5:0] IDX_PORT8_DIR = 6'h08;
  localparam logic [5:0] IDX_RAM_POINTER = 6'h09;
  localparam logic [5:0] IDX_IR_CTRL = 6'h0e;
  localparam logic [5:0] IDX_IRQ_FLAGS = 6'h0f;
  localparam logic [5:0] IDX_PAGE_SEL = 6'h10;
  localparam logic [5:0] IDX_HIGH_PRESET = 6'h11;
  localparam logic [5:0] IDX_LOW_PRESET = 6'h12;
  localparam logic [5:0] IDX_CNT2_PRESET = 6'h13;
  localparam int IDX_MSB = 7;
  localparam int IDX_LSB = 2;
  localparam int LANE0 = 0;
  // ***********************
  // Field positions
  // ***********************
  localparam int IR_ENABLE_BIT = 7;
  localparam int CARRIER_MODE_BIT = 6;
  localparam int LOW_ONLY_BIT = 5;
  localparam int IR_PIN_SEL_BIT = 3;
  localparam int TIMER_PIN_SEL_BIT = 2;
  localparam int IRQ1_PIN_SEL_BIT = 1;
  localparam int IRQ0_PIN_SEL_BIT = 0;
  localparam int FLAG_PORT_CHANGE = 7;
  localparam int FLAG_LOW_TIMER = 6;
  localparam int FLAG_HIGH_TIMER = 5;
  localparam int FLAG_COUNTER_TWO = 4;
  localparam int FLAG_COUNTER_ONE = 3;
  localparam int FLAG_IRQ1 = 2;
  localparam int FLAG_IRQ0 = 1;
  localparam int FLAG_MAIN_TIMER = 0;
  localparam int P5_IR_PIN = 7;
  localparam int P5_TIMER_PIN = 6;
  localparam int P5_IRQ1_PIN = 5;
  localparam int P5_IRQ0_PIN = 4;
  localparam int SEG_P8_UPPER = 3;
  localparam int SEG_P8_LOWER = 2;
  localparam int SEG_P7_UPPER = 1;
  localparam int SEG_P7_LOWER = 0;
  localparam int PAGE_SEL_BIT = 0;
  // ***********************
  // Masks and reset values
  // ***********************
  localparam logic [7:0] IR_CTRL_MASK = 8'hef;
  localparam logic [7:0] RAM_POINTER_MASK = 8'h7f;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PRESET_RESET = 8'h00;
  localparam logic [23:0] UPPER_ZERO = 24'h000000;
endpackage : io_func_pkg

/* io_function_and_irq_status_regs.sv */
`timescale 1ns/1ps
module io_function_and_irq_status_regs (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Port 5 pins 7..4
  input wire logic [7:4] i_port5_data_out,
  input wire logic [7:4] i_port5_pin_in,
  output logic [7:4] o_port5_pin_out,
  output logic [7:4] o_port5_pin_oe,
  // Port 6 pins
  input wire logic [7:0] i_port6_data_out,
  input wire logic [7:0] i_port6_pin_in,
  output logic [7:0] o_port6_pin_out,
  output logic [7:0] o_port6_pin_oe,
  // Port 7 and port 8 pins with segment sharing
  input wire logic [7:0] i_port7_data_out,
  input wire logic [7:0] i_port8_data_out,
  input wire logic [7:0] i_lcd_seg_port7,
  input wire logic [7:0] i_lcd_seg_port8,
  input wire logic [7:0] i_port8_pin_in,
  output logic [7:0] o_port7_pin_out,
  output logic [7:0] o_port7_pin_oe,
  output logic [7:0] o_port8_pin_out,
  output logic [7:0] o_port8_pin_oe,
  // Events from neighbouring timers, same clock
  input wire logic i_counter_one_underflow,
  input wire logic i_main_timer_overflow,
  // Status and function outputs
  output logic [7:0] o_interrupt_flags,
  output logic o_timer_clock_in,
  output logic [6:0] o_data_ram_address
);
  typedef enum logic [1:0] {GEN_IDLE, GEN_HIGH, GEN_LOW} gen_state_t;

  // ***********************
  // Registers
  // ***********************
  logic [7:0] port5_dir_and_segment_select;
  logic [7:0] port6_direction;
  logic [7:0] port7_direction;
  logic [7:0] port8_direction;
  logic [7:0] data_ram_address;
  logic [7:0] infrared_pin_function_control;
  logic [7:0] interrupt_flags;
  logic [7:0] page_select_register;
  logic [7:0] high_width_preset;
  logic [7:0] low_width_preset;
  logic [7:0] counter_two_preset;
  gen_state_t state;
  gen_state_t next_state;
  logic carrier;
  logic [6:4] p5_s1;
  logic [6:4] p5_s2;
  logic [6:4] p5_s3;
  logic [7:0] p6_s1;
  logic [7:0] p6_s2;
  logic [7:0] p6_s3;
  logic [7:0] p8_s1;
  logic [7:0] p8_s2;
  logic [7:0] p8_s3;

  reload_counter_if high_if ();
  reload_counter_if low_if ();
  reload_counter_if cnt2_if ();

  // ***********************
  // Bus decode
  // ***********************
  wire [5:0] idx = i_address[io_func_pkg::IDX_MSB:io_func_pkg::IDX_LSB];
  wire req = i_read || i_write;
  wire take = req && !o_waitrequest;
  wire wr_take = take && i_write && i_byteenable[io_func_pkg::LANE0];
  wire [7:0] wdata = i_writedata[7:0];
  wire page0_open = !page_select_register[io_func_pkg::PAGE_SEL_BIT];
  wire wr_page0 = wr_take && page0_open;
  wire wr_p5 = wr_page0 && (idx == io_func_pkg::IDX_PORT5_CTRL);
  wire wr_p6 = wr_page0 && (idx == io_func_pkg::IDX_PORT6_DIR);
  wire wr_p7 = wr_page0 && (idx == io_func_pkg::IDX_PORT7_DIR);
  wire wr_p8 = wr_page0 && (idx == io_func_pkg::IDX_PORT8_DIR);
  wire wr_ram = wr_page0 && (idx == io_func_pkg::IDX_RAM_POINTER);
  wire wr_ir = wr_take && (idx == io_func_pkg::IDX_IR_CTRL);
  wire wr_flags = wr_take && (idx == io_func_pkg::IDX_IRQ_FLAGS);
  wire wr_page = wr_take && (idx == io_func_pkg::IDX_PAGE_SEL);
  wire wr_high = wr_take && (idx == io_func_pkg::IDX_HIGH_PRESET);
  wire wr_low = wr_take && (idx == io_func_pkg::IDX_LOW_PRESET);
  wire wr_cnt2 = wr_take && (idx == io_func_pkg::IDX_CNT2_PRESET);

  // Closed page and unmapped addresses read as zero
  wire [7:0] rd_value =
    (page0_open && idx == io_func_pkg::IDX_PORT5_CTRL) ?
      port5_dir_and_segment_select :
    (page0_open && idx == io_func_pkg::IDX_PORT6_DIR) ? port6_direction :
    (page0_open && idx == io_func_pkg::IDX_PORT7_DIR) ? port7_direction :
    (page0_open && idx == io_func_pkg::IDX_PORT8_DIR) ? port8_direction :
    (page0_open && idx == io_func_pkg::IDX_RAM_POINTER) ? data_ram_address :
    (idx == io_func_pkg::IDX_IR_CTRL) ? infrared_pin_function_control :
    (idx == io_func_pkg::IDX_IRQ_FLAGS) ? interrupt_flags :
    (idx == io_func_pkg::IDX_PAGE_SEL) ? page_select_register :
    (idx == io_func_pkg::IDX_HIGH_PRESET) ? high_width_preset :
    (idx == io_func_pkg::IDX_LOW_PRESET) ? low_width_preset :
    (idx == io_func_pkg::IDX_CNT2_PRESET) ? counter_two_preset : 8'h00;

  // ***********************
  // Control fields
  // ***********************
  wire ir_enable = infrared_pin_function_control[io_func_pkg::IR_ENABLE_BIT];
  wire carrier_mode =
    infrared_pin_function_control[io_func_pkg::CARRIER_MODE_BIT];
  wire low_only = infrared_pin_function_control[io_func_pkg::LOW_ONLY_BIT];
  wire ir_sel = infrared_pin_function_control[io_func_pkg::IR_PIN_SEL_BIT];
  wire tmr_sel = infrared_pin_function_control[io_func_pkg::TIMER_PIN_SEL_BIT];
  wire irq1_sel = infrared_pin_function_control[io_func_pkg::IRQ1_PIN_SEL_BIT];
  wire irq0_sel = infrared_pin_function_control[io_func_pkg::IRQ0_PIN_SEL_BIT];
  wire [7:0] seg = port5_dir_and_segment_select;

  // ***********************
  // Bus slave
  // ***********************
  // One wait cycle per access: keeps read data a plain registered mux
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_waitrequest <= 1'b1;
    else
      o_waitrequest <= !(req && o_waitrequest);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_readdata <= 32'h00000000;
    else if (req && o_waitrequest)
      o_readdata <= {io_func_pkg::UPPER_ZERO, i_read ? rd_value : 8'h00};
  end

  // ***********************
  // Control registers
  // ***********************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      port5_dir_and_segment_select <= io_func_pkg::DIR_RESET;
      port6_direction <= io_func_pkg::DIR_RESET;
      port7_direction <= io_func_pkg::DIR_RESET;
      port8_direction <= io_func_pkg::DIR_RESET;
      data_ram_address <= io_func_pkg::CTRL_RESET;
      infrared_pin_function_control <= io_func_pkg::CTRL_RESET;
      page_select_register <= io_func_pkg::CTRL_RESET;
    end
    else
    begin
      if (wr_p5)
        port5_dir_and_segment_select <= wdata;
      if (wr_p6)
        port6_direction <= wdata;
      if (wr_p7)
        port7_direction <= wdata;
      if (wr_p8)
        port8_direction <= wdata;
      if (wr_ram)
        data_ram_address <= wdata & io_func_pkg::RAM_POINTER_MASK;
      if (wr_ir)
        infrared_pin_function_control <= wdata & io_func_pkg::IR_CTRL_MASK;
      if (wr_page)
        page_select_register <= wdata;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      high_width_preset <= io_func_pkg::PRESET_RESET;
      low_width_preset <= io_func_pkg::PRESET_RESET;
      counter_two_preset <= io_func_pkg::PRESET_RESET;
    end
    else
    begin
      if (wr_high)
        high_width_preset <= wdata;
      if (wr_low)
        low_width_preset <= wdata;
      if (wr_cnt2)
        counter_two_preset <= wdata;
    end
  end

  // ***********************
  // Pin synchronisers
  // ***********************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      p5_s1 <= 3'h0;
      p5_s2 <= 3'h0;
      p5_s3 <= 3'h0;
      p6_s1 <= 8'h00;
      p6_s2 <= 8'h00;
      p6_s3 <= 8'h00;
      p8_s1 <= 8'h00;
      p8_s2 <= 8'h00;
      p8_s3 <= 8'h00;
    end
    else
    begin
      p5_s1 <= i_port5_pin_in[6:4];
      p5_s2 <= p5_s1;
      p5_s3 <= p5_s2;
      p6_s1 <= i_port6_pin_in;
      p6_s2 <= p6_s1;
      p6_s3 <= p6_s2;
      p8_s1 <= i_port8_pin_in;
      p8_s2 <= p8_s1;
      p8_s3 <= p8_s2;
    end
  end

  // ***********************
  // Waveform generator
  // ***********************
  assign high_if.run = (state == GEN_HIGH);
  assign high_if.preset = high_width_preset;
  assign low_if.run = (state == GEN_LOW);
  assign low_if.preset = low_width_preset;
  // Counter 2 always reloads on its own
  assign cnt2_if.run = 1'b1;
  assign cnt2_if.preset = counter_two_preset;

  reload_counter u_high_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .cnt(high_if.counter)
  );
  reload_counter u_low_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .cnt(low_if.counter)
  );
  reload_counter u_counter_two (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .cnt(cnt2_if.counter)
  );

  always_comb
  begin
    next_state = state;
    case (state)
      GEN_IDLE:
        next_state = ir_enable ? (low_only ? GEN_LOW : GEN_HIGH) : GEN_IDLE;
      GEN_HIGH:
        next_state = (high_if.underflow || low_only) ? GEN_LOW : GEN_HIGH;
      GEN_LOW:
        next_state = (low_if.underflow && !low_only) ? GEN_HIGH : GEN_LOW;
      default:
        next_state = GEN_IDLE;
    endcase
    if (!ir_enable)
      next_state = GEN_IDLE;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      state <= GEN_IDLE;
    else
      state <= next_state;
  end

  // Carrier period is 2*(preset+1) cycles
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      carrier <= 1'b0;
    else if (cnt2_if.underflow)
      carrier <= !carrier;
  end

  wire wave = (state == GEN_HIGH) ||
              ((state == GEN_LOW) && carrier_mode && carrier);

  // ***********************
  // Pin muxing
  // ***********************
  // Waveform routed to pin 7
  wire ir_on_pin = ir_enable && ir_sel;
  wire [7:4] p5_out = {ir_on_pin ? wave : i_port5_data_out[7],
                       i_port5_data_out[6:4]};
  wire [7:0] p7_seg = {{4{seg[io_func_pkg::SEG_P7_UPPER]}},
                       {4{seg[io_func_pkg::SEG_P7_LOWER]}}};
  wire [7:0] p8_seg = {{4{seg[io_func_pkg::SEG_P8_UPPER]}},
                       {4{seg[io_func_pkg::SEG_P8_LOWER]}}};

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_port5_pin_out <= 4'h0;
      o_port5_pin_oe <= 4'h0;
      o_port6_pin_out <= 8'h00;
      o_port6_pin_oe <= 8'h00;
      o_port7_pin_out <= 8'h00;
      o_port7_pin_oe <= 8'h00;
      o_port8_pin_out <= 8'h00;
      o_port8_pin_oe <= 8'h00;
    end
    else
    begin
      o_port5_pin_out <= p5_out;
      o_port5_pin_oe <= ~seg[7:4];
      o_port6_pin_out <= i_port6_data_out;
      o_port6_pin_oe <= ~port6_direction;
      o_port7_pin_out <= (p7_seg & i_lcd_seg_port7) |
                         (~p7_seg & i_port7_data_out);
      o_port7_pin_oe <= p7_seg | ~port7_direction;
      o_port8_pin_out <= (p8_seg & i_lcd_seg_port8) |
                         (~p8_seg & i_port8_data_out);
      o_port8_pin_oe <= p8_seg | ~port8_direction;
    end
  end

  // ***********************
  // Interrupt flags
  // ***********************
  // Timer clock from pin 6
  wire tmr_pin = tmr_sel && p5_s2[io_func_pkg::P5_TIMER_PIN];
  wire irq1_evt = irq1_sel && p5_s2[io_func_pkg::P5_IRQ1_PIN] &&
                  !p5_s3[io_func_pkg::P5_IRQ1_PIN];
  wire irq0_evt = irq0_sel && p5_s2[io_func_pkg::P5_IRQ0_PIN] &&
                  !p5_s3[io_func_pkg::P5_IRQ0_PIN];
  // Input change on ports 6 and 8
  wire port_chg = |((p6_s2 ^ p6_s3) & port6_direction) ||
                  |((p8_s2 ^ p8_s3) & port8_direction & ~p8_seg);

  wire [7:0] events;
  assign events[io_func_pkg::FLAG_PORT_CHANGE] = port_chg;
  assign events[io_func_pkg::FLAG_LOW_TIMER] = low_if.underflow;
  assign events[io_func_pkg::FLAG_HIGH_TIMER] = high_if.underflow;
  assign events[io_func_pkg::FLAG_COUNTER_TWO] = cnt2_if.underflow;
  assign events[io_func_pkg::FLAG_COUNTER_ONE] = i_counter_one_underflow;
  assign events[io_func_pkg::FLAG_IRQ1] = irq1_evt;
  assign events[io_func_pkg::FLAG_IRQ0] = irq0_evt;
  assign events[io_func_pkg::FLAG_MAIN_TIMER] = i_main_timer_overflow;

  wire [7:0] next_flags = (interrupt_flags & (wr_flags ? wdata : 8'hff)) |
                          events;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      interrupt_flags <= io_func_pkg::CTRL_RESET;
      o_interrupt_flags <= io_func_pkg::CTRL_RESET;
      o_timer_clock_in <= 1'b0;
      o_data_ram_address <= 7'h00;
    end
    else
    begin
      interrupt_flags <= next_flags;
      o_interrupt_flags <= next_flags;
      o_timer_clock_in <= tmr_pin;
      o_data_ram_address <= data_ram_address[6:0];
    end
  end

  // ***********************
  // Assertions
  // ***********************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_access_start;
    req && o_waitrequest;
  endsequence
  sequence s_closed_page_read;
    s_access_start ##0 i_read && !page0_open &&
      idx >= io_func_pkg::IDX_PORT5_CTRL &&
      idx <= io_func_pkg::IDX_RAM_POINTER;
  endsequence
  sequence s_irq0_rise;
    irq0_sel && !p5_s2[io_func_pkg::P5_IRQ0_PIN] ##1
      irq0_sel && p5_s2[io_func_pkg::P5_IRQ0_PIN];
  endsequence

  property p_answer_next;
    s_access_start |=> !o_waitrequest;
  endproperty
  a_answer_next: assert property (p_answer_next)
    else $error("Access not answered one cycle after it began");

  property p_closed_page;
    s_closed_page_read |=> o_readdata == 32'h00000000;
  endproperty
  a_closed_page: assert property (p_closed_page)
    else $error("Page zero register readable with page select set");

  property p_gen_off;
    !ir_enable |=> state == GEN_IDLE;
  endproperty
  a_gen_off: assert property (p_gen_off)
    else $error("Generator still running after disable");

  property p_gen_on;
    ir_enable && state == GEN_IDLE |=> state != GEN_IDLE;
  endproperty
  a_gen_on: assert property (p_gen_on)
    else $error("Generator did not start after enable");

  property p_low_only;
    low_only |=> state != GEN_HIGH;
  endproperty
  a_low_only: assert property (p_low_only)
    else $error("High phase entered in low-pulse-only mode");

  property p_plain_low;
    state == GEN_LOW && !carrier_mode |-> !wave;
  endproperty
  a_plain_low: assert property (p_plain_low)
    else $error("Low section not low without carrier mode");

  property p_ir_pin;
    ir_on_pin |=> o_port5_pin_out[io_func_pkg::P5_IR_PIN] == $past(wave);
  endproperty
  a_ir_pin: assert property (p_ir_pin)
    else $error("Waveform not on infrared pin");

  property p_irq0_flag;
    s_irq0_rise |=> interrupt_flags[io_func_pkg::FLAG_IRQ0];
  endproperty
  a_irq0_flag: assert property (p_irq0_flag)
    else $error("Interrupt 0 edge did not set its flag");

  property p_low_flag;
    low_if.underflow |=> interrupt_flags[io_func_pkg::FLAG_LOW_TIMER];
  endproperty
  a_low_flag: assert property (p_low_flag)
    else $error("Low width underflow did not set its flag");

  property p_flag_sticky;
    interrupt_flags[io_func_pkg::FLAG_PORT_CHANGE] && !wr_flags |=>
      interrupt_flags[io_func_pkg::FLAG_PORT_CHANGE];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("Status flag dropped without a clearing write");
endmodule : io_function_and_irq_status_regs

/* io_function_and_irq_status_regs_test.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("unexpected %s exp %h got %h", nm, e, g); \
    end \
  end
module io_function_and_irq_status_regs_test;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_read = 1'b0, i_write = 1'b0;
  logic [7:0] i_address = 8'h00;
  logic [31:0] i_writedata = 32'h0, o_readdata;
  logic [3:0] i_byteenable = 4'hf;
  logic o_waitrequest, o_timer_clock_in;
  logic [7:4] i_port5_data_out = 4'h0, i_port5_pin_in = 4'h0;
  logic [7:4] o_port5_pin_out, o_port5_pin_oe;
  logic [7:0] i_port6_data_out = 8'h00, i_port6_pin_in = 8'h00;
  logic [7:0] i_port7_data_out = 8'h00, i_port8_data_out = 8'h00;
  logic [7:0] i_lcd_seg_port7 = 8'h00, i_lcd_seg_port8 = 8'h00;
  logic [7:0] i_port8_pin_in = 8'h00, o_interrupt_flags;
  logic [7:0] o_port6_pin_out, o_port6_pin_oe, o_port7_pin_out;
  logic [7:0] o_port7_pin_oe, o_port8_pin_out, o_port8_pin_oe, rd;
  logic i_counter_one_underflow = 1'b0, i_main_timer_overflow = 1'b0;
  logic [6:0] o_data_ram_address;
  int err_total = 0, samples_checked = 0, cycles = 0, n;
  io_function_and_irq_status_regs uut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_port5_data_out(i_port5_data_out),
    .i_port5_pin_in(i_port5_pin_in), .o_port5_pin_out(o_port5_pin_out),
    .o_port5_pin_oe(o_port5_pin_oe), .i_port6_data_out(i_port6_data_out),
    .i_port6_pin_in(i_port6_pin_in), .o_port6_pin_out(o_port6_pin_out),
    .o_port6_pin_oe(o_port6_pin_oe), .i_port7_data_out(i_port7_data_out),
    .i_port8_data_out(i_port8_data_out), .i_lcd_seg_port7(i_lcd_seg_port7),
    .i_lcd_seg_port8(i_lcd_seg_port8), .i_port8_pin_in(i_port8_pin_in),
    .o_port7_pin_out(o_port7_pin_out), .o_port7_pin_oe(o_port7_pin_oe),
    .o_port8_pin_out(o_port8_pin_out), .o_port8_pin_oe(o_port8_pin_oe),
    .i_counter_one_underflow(i_counter_one_underflow),
    .i_main_timer_overflow(i_main_timer_overflow),
    .o_interrupt_flags(o_interrupt_flags),
    .o_timer_clock_in(o_timer_clock_in),
    .o_data_ram_address(o_data_ram_address)
  );
  always #50 i_clk = ~i_clk;
  // ******************
  // Bus tasks
  // ******************
  task automatic bus(input logic wr_en, input logic [5:0] idx,
    input logic [7:0] d, input logic [3:0] be);
    int t;
    @(posedge i_clk);
    i_address <= {idx, 2'b00};
    i_read <= !wr_en;
    i_write <= wr_en;
    i_writedata <= {24'h000000, d};
    i_byteenable <= be;
    t = 0;
    // Request held until waitrequest is seen low
    do
    begin
      @(posedge i_clk);
      t++;
    end
    while (o_waitrequest !== 1'b0);
    rd = o_readdata[7:0];
    i_read <= 1'b0;
    i_write <= 1'b0;
    `CHK("wait cycles", 2, t)
  endtask : bus
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hf);
  endtask : wr
  task automatic rc(input string nm, input logic [5:0] idx,
    input logic [7:0] e, input logic [7:0] m);
    bus(1'b0, idx, 8'h00, 4'hf);
    `CHK(nm, e, rd & m)
  endtask : rc
  task automatic pulse(input int which);
    @(posedge i_clk);
    if (which == 0)
      i_counter_one_underflow <= 1'b1;
    else
      i_main_timer_overflow <= 1'b1;
    @(posedge i_clk);
    i_counter_one_underflow <= 1'b0;
    i_main_timer_overflow <= 1'b0;
  endtask : pulse
  // Length of the next whole run of lvl on pin 7, bounded
  task automatic runlen(input logic lvl, output int len);
    int t;
    t = 0;
    len = 0;
    while (o_port5_pin_out[7] !== !lvl && t < 100)
    begin
      @(posedge i_clk);
      t++;
    end
    while (o_port5_pin_out[7] !== lvl && t < 200)
    begin
      @(posedge i_clk);
      t++;
    end
    while (o_port5_pin_out[7] === lvl && len < 100)
    begin
      @(posedge i_clk);
      len++;
    end
  endtask : runlen
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  // Whole run is about 200 cycles
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      test_done;
    end
  end
  // ******************
  // Tests
  // ******************
  initial
  begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rc("p6 dir", io_func_pkg::IDX_PORT6_DIR, 8'hff, 8'hff);
    rc("p7 dir", io_func_pkg::IDX_PORT7_DIR, 8'hff, 8'hff);
    rc("p8 dir", io_func_pkg::IDX_PORT8_DIR, 8'hff, 8'hff);
    rc("ram addr", io_func_pkg::IDX_RAM_POINTER, 8'h00, 8'hff);
    rc("flags", io_func_pkg::IDX_IRQ_FLAGS, 8'h00, 8'h0f);
    $display("test reset done");
    wr(io_func_pkg::IDX_RAM_POINTER, 8'hff);
    rc("ram addr", io_func_pkg::IDX_RAM_POINTER, 8'h7f, 8'hff);
    `CHK("ram out", 7'h7f, o_data_ram_address)
    wr(io_func_pkg::IDX_IR_CTRL, 8'hff);
    rc("ir ctrl", io_func_pkg::IDX_IR_CTRL, 8'hef, 8'hff);
    wr(io_func_pkg::IDX_IR_CTRL, 8'h00);
    bus(1'b1, io_func_pkg::IDX_PORT7_DIR, 8'h00, 4'he);
    rc("lane off", io_func_pkg::IDX_PORT7_DIR, 8'hff, 8'hff);
    rc("unmapped", 6'h3f, 8'h00, 8'hff);
    wr(io_func_pkg::IDX_PAGE_SEL, 8'h01);
    wr(io_func_pkg::IDX_PORT6_DIR, 8'h00);
    rc("page 1", io_func_pkg::IDX_PORT6_DIR, 8'h00, 8'hff);
    wr(io_func_pkg::IDX_PAGE_SEL, 8'h00);
    rc("page 0", io_func_pkg::IDX_PORT6_DIR, 8'hff, 8'hff);
    $display("test access done");
    i_port6_data_out <= 8'ha5;
    i_port7_data_out <= 8'h5a;
    i_lcd_seg_port7 <= 8'h3c;
    i_lcd_seg_port8 <= 8'hc3;
    i_port5_data_out <= 4'ha;
    wr(io_func_pkg::IDX_PORT6_DIR, 8'h0f);
    wr(io_func_pkg::IDX_PORT7_DIR, 8'h00);
    wr(io_func_pkg::IDX_PORT5_CTRL, 8'h49);
    repeat (3) @(posedge i_clk);
    `CHK("p6 oe", 8'hf0, o_port6_pin_oe)
    `CHK("p6 out", 8'ha0, o_port6_pin_out & 8'hf0)
    `CHK("p7 oe", 4'hf, o_port7_pin_oe[7:4])
    `CHK("p7 out", 4'h5, o_port7_pin_out[7:4])
    `CHK("p7 seg", 4'hc, o_port7_pin_out[3:0])
    `CHK("p8 seg", 4'hc, o_port8_pin_out[7:4])
    `CHK("p8 oe", 8'hf0, o_port8_pin_oe)
    `CHK("p5 oe", 4'hb, o_port5_pin_oe)
    `CHK("p5 out", 4'ha, o_port5_pin_out & 4'hb)
    $display("test pins done");
    pulse(0);
    pulse(1);
    repeat (2) @(posedge i_clk);
    rc("flag set", io_func_pkg::IDX_IRQ_FLAGS, 8'h19, 8'h1f);
    wr(io_func_pkg::IDX_IRQ_FLAGS, 8'hff);
    rc("flag keep", io_func_pkg::IDX_IRQ_FLAGS, 8'h09, 8'h0f);
    wr(io_func_pkg::IDX_IRQ_FLAGS, 8'hf6);
    rc("flag clr", io_func_pkg::IDX_IRQ_FLAGS, 8'h00, 8'h0f);
    i_port6_pin_in <= 8'h01;
    repeat (5) @(posedge i_clk);
    `CHK("p6 change", 1'b1, o_interrupt_flags[7])
    wr(io_func_pkg::IDX_IRQ_FLAGS, 8'h7f);
    i_port8_pin_in <= 8'h02;
    repeat (5) @(posedge i_clk);
    `CHK("p8 change", 1'b1, o_interrupt_flags[7])
    wr(io_func_pkg::IDX_IR_CTRL, 8'h07);
    wr(io_func_pkg::IDX_PORT5_CTRL, 8'h79);
    wr(io_func_pkg::IDX_IRQ_FLAGS, 8'h00);
    i_port5_pin_in <= 4'h7;
    repeat (5) @(posedge i_clk);
    rc("ext irq", io_func_pkg::IDX_IRQ_FLAGS, 8'h06, 8'h06);
    `CHK("tmr clk hi", 1'b1, o_timer_clock_in)
    i_port5_pin_in <= 4'h0;
    repeat (5) @(posedge i_clk);
    `CHK("tmr clk lo", 1'b0, o_timer_clock_in)
    $display("test flags done");
    wr(io_func_pkg::IDX_HIGH_PRESET, 8'h02);
    wr(io_func_pkg::IDX_LOW_PRESET, 8'h03);
    wr(io_func_pkg::IDX_IRQ_FLAGS, 8'h00);
    wr(io_func_pkg::IDX_IR_CTRL, 8'h88);
    runlen(1'b1, n);
    `CHK("high run", 3, n)
    runlen(1'b0, n);
    `CHK("low run", 4, n)
    rc("width flags", io_func_pkg::IDX_IRQ_FLAGS, 8'h60, 8'h60);
    wr(io_func_pkg::IDX_CNT2_PRESET, 8'h01);
    wr(io_func_pkg::IDX_IR_CTRL, 8'he8);
    runlen(1'b1, n);
    `CHK("carrier run", 2, n)
    wr(io_func_pkg::IDX_IR_CTRL, 8'ha8);
    repeat (3) @(posedge i_clk);
    n = 0;
    repeat (20)
    begin
      @(posedge i_clk);
      n += (o_port5_pin_out[7] === 1'b1);
    end
    `CHK("low only", 0, n)
    wr(io_func_pkg::IDX_IR_CTRL, 8'h00);
    repeat (3) @(posedge i_clk);
    `CHK("plain pin", 1'b1, o_port5_pin_out[7])
    $display("test generator done");
    test_done;
  end
endmodule : io_function_and_irq_status_regs_test

/* reload_counter.sv */
`timescale 1ns/1ps
module reload_counter (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control side
  reload_counter_if.counter cnt
);
  logic [7:0] count;

  // Idle counter sits at its preset, so a new phase lasts preset+1 cycles
  assign cnt.underflow = cnt.run && (count == 8'h00);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      count <= 8'h00;
    else if (!cnt.run || cnt.underflow)
      count <= cnt.preset;
    else
      count <= count - 8'h01;
  end

  property p_reload_after_underflow;
    @(posedge i_clk) disable iff (!i_rst_n)
      cnt.underflow |=> (count == $past(cnt.preset));
  endproperty
  a_reload_after_underflow: assert property (p_reload_after_underflow)
    else $error("Counter did not reload its preset after underflow");
endmodule : reload_counter

/* reload_counter_if.sv */
`timescale 1ns/1ps
interface reload_counter_if;
  logic run;
  logic [7:0] preset;
  logic underflow;
  modport ctrl (output run, output preset, input underflow);
  modport counter (input run, input preset, output underflow);
endinterface : reload_counter_if
